// ### core/port_a_pkg.sv
// Shared constants for the port A pin control block
package port_a_pkg;
  localparam int          NUM_PINS         = 8;
  localparam int          NUM_SRC          = 5;
  localparam int          ANALOG_W         = 6;
  localparam int          ALT_W            = 7;
  // Register byte offsets on the bus
  localparam logic [7:0]  OFF_PIN_VALUE    = 8'h00;
  localparam logic [7:0]  OFF_DIRECTION    = 8'h04;
  localparam logic [7:0]  OFF_LATCH        = 8'h08;
  localparam logic [7:0]  OFF_ANALOG       = 8'h0C;
  localparam logic [7:0]  OFF_ALT_FUNC     = 8'h10;
  // Reset values
  localparam logic [7:0]  DIR_RST          = 8'hFF;
  localparam logic [7:0]  LATCH_RST        = 8'h00;
  localparam logic [5:0]  ANALOG_RST       = 6'h3F;
  localparam logic [6:0]  ALT_RST          = 7'h00;
  // Field positions in the alternate function register
  localparam int          ALT_PWM_B_BIT    = 4;
  localparam int          ALT_TGATE_BIT    = 5;
  // Source slots, highest priority first
  localparam int          SLOT_0           = 0;
  localparam int          SLOT_1           = 1;
  localparam int          SLOT_2           = 2;
  localparam int          SLOT_3           = 3;
endpackage

// ### core/pin_src_if.sv
// Peripheral source requests per pin and the resolved pin drive
`timescale 1ns/100ps
`default_nettype none
interface pin_src_if;
  logic [7:0][4:0] src_en;
  logic [7:0][4:0] src_val;
  logic [7:0][4:0] src_drv;
  logic [7:0]      latch;
  logic [7:0]      dir;
  logic [7:0]      pin_oe;
  logic [7:0]      pin_out;
  modport driver (output src_en, src_val, src_drv, latch, dir, input pin_oe, pin_out);
  modport mux    (input src_en, src_val, src_drv, latch, dir, output pin_oe, pin_out);
endinterface
`default_nettype wire

// ### core/pin_sync.sv
// Two-stage synchroniser for pin levels
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_s;

  sync_s r;
  sync_s n;

  always_comb begin
    n        = r;
    n.meta   = d_i;
    n.stable = r.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign q_o = r.stable;
endmodule // pin_sync
`default_nettype wire

// ### core/pin_priority_mux.sv
// Per-pin output owner selection by fixed priority
`timescale 1ns/100ps
`default_nettype none
module pin_priority_mux (
  pin_src_if.mux pins
);
  // Walk from the highest slot index down so the highest priority enabled source, slot 0, is applied last
  always_comb begin
    for (int p = 0; p < port_a_pkg::NUM_PINS; p++) begin
      pins.pin_oe[p]  = ~pins.dir[p];   // RULE1 RULE2 RULE6
      pins.pin_out[p] = pins.latch[p];  // RULE2
      for (int s = port_a_pkg::NUM_SRC - 1; s >= 0; s--) begin
        if (pins.src_en[p][s]) begin
          pins.pin_oe[p]  = pins.src_drv[p][s]; // RULE12
          pins.pin_out[p] = pins.src_val[p][s];
        end
      end
    end
  end
endmodule // pin_priority_mux
`default_nettype wire

// ### core/port_a_pin_control.sv
// Port A pin control: registers, pin sampling, output ownership, steering
//
// How it works
// RULE1: Direction one makes pin input, driver off
// RULE2: Direction zero drives pin from output latch
// RULE3: Eight pins, each own direction and latch
// RULE4: Value reads give pins; writes go to latch
// RULE5: Port writes sample pins, modify, store latch
// RULE6: Direction still controls drivers in analog mode
// RULE7: Software keeps analog pins set as inputs
// RULE8: Analog-selected pins read as zero digitally
// RULE9: Analog select never blocks digital output
// RULE10: Analog select bits reset to analog mode
// RULE11: Software clears analog select for digital inputs
// RULE12: Highest priority enabled source owns the pin
// RULE13: Peripheral outputs still drive analog-mode pins
// RULE14: Analog functions enabled only by analog select
// RULE15: Pin 0 order: regulator, display_segment_12, nq, cmp2, latch
// RULE16: Pin 5 order: regulator, display_segment_5, nq, cmp2, latch
// RULE17: Pin 3 order: common3 small package, display_segment_15, latch
// RULE18: Pin 4 order: display_segment_4, q, cmp1, capture_compare_5, latch; code honours capture_compare_5 only with small_package_i
// RULE19: Pin 6 order: regulator, crystal, clockout, display_segment_1, latch
// RULE20: Pin 7 order: crystal input, display_segment_2, latch
// RULE21: Bit 5 picks timer gate source pin
// RULE22: Bit 4 picks PWM B pin, large variant
// RULE23: Steering leaves direction; unselected pin untouched
// RULE24: Latch register write as port; read gives latch
// RULE25: Pin inputs synchronised before any use
//
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module port_a_pin_control #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Port A pads
  input  wire logic [7:0]  pad_in_i,
  output logic      [7:0]  pad_out_o,
  output logic      [7:0]  pad_oe_o,
  output logic      [5:0]  analog_input_enable_o,
  // Configuration and package straps
  input  wire logic        small_package_i,
  input  wire logic        regulator_capacitor_pin0_en_i,
  input  wire logic        regulator_capacitor_pin5_en_i,
  input  wire logic        regulator_capacitor_pin6_en_i,
  input  wire logic        crystal_output_en_i,
  input  wire logic        crystal_or_clock_input_en_i,
  input  wire logic        clock_output_en_i,
  input  wire logic        clock_output_i,
  // Display driver outputs
  input  wire logic        display_segment_12_en_i,
  input  wire logic        display_segment_12_i,
  input  wire logic        display_common_3_en_i,
  input  wire logic        display_common_3_i,
  input  wire logic        display_segment_15_en_i,
  input  wire logic        display_segment_15_i,
  input  wire logic        display_segment_4_en_i,
  input  wire logic        display_segment_4_i,
  input  wire logic        display_segment_5_en_i,
  input  wire logic        display_segment_5_i,
  input  wire logic        display_segment_1_en_i,
  input  wire logic        display_segment_1_i,
  input  wire logic        display_segment_2_en_i,
  input  wire logic        display_segment_2_i,
  // Latch, comparator and capture outputs; [0] pin 0, [1] pin 5
  input  wire logic [1:0]  latch_inverted_output_en_i,
  input  wire logic        latch_inverted_output_i,
  input  wire logic        latch_true_output_en_i,
  input  wire logic        latch_true_output_i,
  input  wire logic [1:0]  comparator2_output_en_i,
  input  wire logic        comparator2_output_i,
  input  wire logic        comparator1_output_en_i,
  input  wire logic        comparator1_output_i,
  input  wire logic        capture_compare_5_en_i,
  input  wire logic        capture_compare_5_i,
  // Steered functions
  input  wire logic        b_side_pin5_i,
  input  wire logic        c_side_pin4_i,
  output logic             timer_gate_input_o,
  input  wire logic        pwm_b_output_en_i,
  input  wire logic        pwm_b_output_i,
  output logic             c_side_pin0_pwm_b_en_o,
  output logic             c_side_pin0_pwm_b_o,
  output logic             d_side_pin2_pwm_b_en_o,
  output logic             d_side_pin2_pwm_b_o
);
  typedef struct packed {
    logic [7:0]                    dir;
    logic [7:0]                    latch;
    logic [port_a_pkg::ANALOG_W-1:0] analog;
    logic [port_a_pkg::ALT_W-1:0]    alt;
    logic                          ack;
    logic [7:0]                    rdat;
    logic [7:0]                    pad_out;
    logic [7:0]                    pad_oe;
    logic                          tgate;
    logic                          pwm_c_en;
    logic                          pwm_c;
    logic                          pwm_d_en;
    logic                          pwm_d;
  } state_s;

  state_s     r;
  state_s     n;
  logic [9:0] sync_q;
  logic [7:0] pin_read;
  logic       req;
  logic       pwm_on_d;

  pin_src_if pins ();

  // Both port-value and latch writes load the latch
  function automatic logic latch_write(input logic [7:0] a);
    return (a == port_a_pkg::OFF_PIN_VALUE) || (a == port_a_pkg::OFF_LATCH);
  endfunction

  // Pads and the other-port pins are asynchronous to clk_i
  pin_sync #(
    .W (10)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({c_side_pin4_i, b_side_pin5_i, pad_in_i}), // RULE25
    .q_o   (sync_q)
  );

  pin_priority_mux u_mux (
    .pins (pins.mux)
  );

  // Digital input buffer is off on analog pins, so they read zero
  assign pin_read = sync_q[7:0] & ~{2'b00, r.analog}; // RULE8 RULE4
  assign req      = cyc_i && stb_i && !r.ack;
  assign pwm_on_d = LARGE_VARIANT && r.alt[port_a_pkg::ALT_PWM_B_BIT]; // RULE22

  // Peripheral source slots; analog select is deliberately not consulted
  always_comb begin
    pins.src_en  = '0;
    pins.src_val = '0;
    pins.src_drv = '0;
    pins.latch   = r.latch;
    pins.dir     = r.dir; // RULE6 RULE23
    // Pin 0
    pins.src_en[0][port_a_pkg::SLOT_0]  = regulator_capacitor_pin0_en_i; // RULE15
    pins.src_en[0][port_a_pkg::SLOT_1]  = display_segment_12_en_i;
    pins.src_val[0][port_a_pkg::SLOT_1] = display_segment_12_i;
    pins.src_drv[0][port_a_pkg::SLOT_1] = 1'b1;
    pins.src_en[0][port_a_pkg::SLOT_2]  = latch_inverted_output_en_i[0];
    pins.src_val[0][port_a_pkg::SLOT_2] = latch_inverted_output_i;
    pins.src_drv[0][port_a_pkg::SLOT_2] = 1'b1;
    pins.src_en[0][port_a_pkg::SLOT_3]  = comparator2_output_en_i[0];
    pins.src_val[0][port_a_pkg::SLOT_3] = comparator2_output_i;
    pins.src_drv[0][port_a_pkg::SLOT_3] = 1'b1;
    // Pin 3
    pins.src_en[3][port_a_pkg::SLOT_0]  = display_common_3_en_i && small_package_i; // RULE17
    pins.src_val[3][port_a_pkg::SLOT_0] = display_common_3_i;
    pins.src_drv[3][port_a_pkg::SLOT_0] = 1'b1;
    pins.src_en[3][port_a_pkg::SLOT_1]  = display_segment_15_en_i;
    pins.src_val[3][port_a_pkg::SLOT_1] = display_segment_15_i;
    pins.src_drv[3][port_a_pkg::SLOT_1] = 1'b1;
    // Pin 4
    pins.src_en[4][port_a_pkg::SLOT_0]  = display_segment_4_en_i; // RULE18
    pins.src_val[4][port_a_pkg::SLOT_0] = display_segment_4_i;
    pins.src_drv[4][port_a_pkg::SLOT_0] = 1'b1;
    pins.src_en[4][port_a_pkg::SLOT_1]  = latch_true_output_en_i;
    pins.src_val[4][port_a_pkg::SLOT_1] = latch_true_output_i;
    pins.src_drv[4][port_a_pkg::SLOT_1] = 1'b1;
    pins.src_en[4][port_a_pkg::SLOT_2]  = comparator1_output_en_i;
    pins.src_val[4][port_a_pkg::SLOT_2] = comparator1_output_i;
    pins.src_drv[4][port_a_pkg::SLOT_2] = 1'b1;
    pins.src_en[4][port_a_pkg::SLOT_3]  = capture_compare_5_en_i && small_package_i;
    pins.src_val[4][port_a_pkg::SLOT_3] = capture_compare_5_i;
    pins.src_drv[4][port_a_pkg::SLOT_3] = 1'b1;
    // Pin 5
    pins.src_en[5][port_a_pkg::SLOT_0]  = regulator_capacitor_pin5_en_i; // RULE16
    pins.src_en[5][port_a_pkg::SLOT_1]  = display_segment_5_en_i;
    pins.src_val[5][port_a_pkg::SLOT_1] = display_segment_5_i;
    pins.src_drv[5][port_a_pkg::SLOT_1] = 1'b1;
    pins.src_en[5][port_a_pkg::SLOT_2]  = latch_inverted_output_en_i[1];
    pins.src_val[5][port_a_pkg::SLOT_2] = latch_inverted_output_i;
    pins.src_drv[5][port_a_pkg::SLOT_2] = 1'b1;
    pins.src_en[5][port_a_pkg::SLOT_3]  = comparator2_output_en_i[1];
    pins.src_val[5][port_a_pkg::SLOT_3] = comparator2_output_i;
    pins.src_drv[5][port_a_pkg::SLOT_3] = 1'b1;
    // Pin 6; regulator and crystal are analog owners, so the driver goes off
    pins.src_en[6][port_a_pkg::SLOT_0]  = regulator_capacitor_pin6_en_i; // RULE19
    pins.src_en[6][port_a_pkg::SLOT_1]  = crystal_output_en_i;
    pins.src_en[6][port_a_pkg::SLOT_2]  = clock_output_en_i;
    pins.src_val[6][port_a_pkg::SLOT_2] = clock_output_i;
    pins.src_drv[6][port_a_pkg::SLOT_2] = 1'b1;
    pins.src_en[6][port_a_pkg::SLOT_3]  = display_segment_1_en_i;
    pins.src_val[6][port_a_pkg::SLOT_3] = display_segment_1_i;
    pins.src_drv[6][port_a_pkg::SLOT_3] = 1'b1;
    // Pin 7
    pins.src_en[7][port_a_pkg::SLOT_0]  = crystal_or_clock_input_en_i; // RULE20
    pins.src_en[7][port_a_pkg::SLOT_1]  = display_segment_2_en_i;
    pins.src_val[7][port_a_pkg::SLOT_1] = display_segment_2_i;
    pins.src_drv[7][port_a_pkg::SLOT_1] = 1'b1;
  end

  always_comb begin
    n      = r;
    n.ack  = req;
    n.rdat = 8'h00;
    if (req && we_i && sel_i[0]) begin
      case (adr_i)
        port_a_pkg::OFF_DIRECTION: n.dir    = dat_i[7:0]; // RULE3
        port_a_pkg::OFF_ANALOG:    n.analog = dat_i[port_a_pkg::ANALOG_W-1:0];
        port_a_pkg::OFF_ALT_FUNC:  n.alt    = dat_i[port_a_pkg::ALT_W-1:0];
        default:                   n.alt    = r.alt;
      endcase
    end
    // Unwritten byte lane keeps the sampled pin levels
    if (req && we_i && latch_write(adr_i)) begin
      n.latch = sel_i[0] ? dat_i[7:0] : pin_read; // RULE5 RULE4 RULE24
    end
    if (req && !we_i) begin
      case (adr_i)
        port_a_pkg::OFF_PIN_VALUE: n.rdat = pin_read; // RULE4
        port_a_pkg::OFF_DIRECTION: n.rdat = r.dir;
        port_a_pkg::OFF_LATCH:     n.rdat = r.latch; // RULE24
        port_a_pkg::OFF_ANALOG:    n.rdat = {2'b00, r.analog};
        port_a_pkg::OFF_ALT_FUNC:  n.rdat = {1'b0, r.alt};
        default:                   n.rdat = 8'h00;
      endcase
    end
    n.pad_out = pins.pin_out; // RULE9 RULE13
    n.pad_oe  = pins.pin_oe;
    n.tgate   = r.alt[port_a_pkg::ALT_TGATE_BIT] ? sync_q[9] : sync_q[8]; // RULE21
    // Only the selected pin sees the PWM B request
    n.pwm_c_en = pwm_b_output_en_i && !pwm_on_d; // RULE23
    n.pwm_c    = pwm_b_output_i && !pwm_on_d;
    n.pwm_d_en = pwm_b_output_en_i && pwm_on_d;
    n.pwm_d    = pwm_b_output_i && pwm_on_d;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r        <= '0;
      r.dir    <= port_a_pkg::DIR_RST;
      r.latch  <= port_a_pkg::LATCH_RST;
      r.analog <= port_a_pkg::ANALOG_RST; // RULE10
      r.alt    <= port_a_pkg::ALT_RST;
    end else begin
      r <= n;
    end
  end

  assign dat_o                  = {24'h000000, r.rdat};
  assign ack_o                  = r.ack;
  assign pad_out_o              = r.pad_out;
  assign pad_oe_o               = r.pad_oe;
  assign analog_input_enable_o  = r.analog; // RULE14
  assign timer_gate_input_o     = r.tgate;
  assign c_side_pin0_pwm_b_en_o = r.pwm_c_en;
  assign c_side_pin0_pwm_b_o    = r.pwm_c;
  assign d_side_pin2_pwm_b_en_o = r.pwm_d_en;
  assign d_side_pin2_pwm_b_o    = r.pwm_d;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered in one cycle");
  a_input_no_drive: assert property ( // RULE1
    (r.dir == 8'hFF) && (pins.src_en == '0) |=> (pad_oe_o == 8'h00))
    else $error("input pin driven");
  a_output_drives_latch: assert property ( // RULE2
    (r.dir == 8'h00) && (pins.src_en == '0) |=> (pad_oe_o == 8'hFF) && (pad_out_o == $past(r.latch)))
    else $error("output pin not driving latch");
  a_analog_reads_zero: assert property ( // RULE8
    req && !we_i && (adr_i == port_a_pkg::OFF_PIN_VALUE)
    |=> ((dat_o[5:0] & $past(r.analog)) == 6'h00))
    else $error("analog pin read as one");
  a_rmw_latch_write: assert property ( // RULE5
    req && we_i && sel_i[0] && latch_write(adr_i) |=> (r.latch == $past(dat_i[7:0])))
    else $error("port write did not reach latch");
  a_latch_read_back: assert property ( // RULE24
    req && !we_i && (adr_i == port_a_pkg::OFF_LATCH) |=> (dat_o[7:0] == $past(r.latch)))
    else $error("latch read returned wrong value");
  a_reset_analog_mode: assert property ( // RULE10
    $past(rst_i) |-> (analog_input_enable_o == port_a_pkg::ANALOG_RST))
    else $error("analog select not in analog mode after reset");
  a_timer_gate_route: assert property ( // RULE21
    ##1 1'b1 |-> (timer_gate_input_o ==
      ($past(r.alt[port_a_pkg::ALT_TGATE_BIT]) ? $past(sync_q[9]) : $past(sync_q[8]))))
    else $error("timer gate taken from wrong pin");
  a_pwm_one_pin: assert property ( // RULE23
    !(c_side_pin0_pwm_b_en_o && d_side_pin2_pwm_b_en_o))
    else $error("PWM B steered to both pins");

  // Priority per pin: each case checks the winner or the latch fallback
  a_pin0_regulator_wins: assert property ( // RULE15
    regulator_capacitor_pin0_en_i |=> !pad_oe_o[0] && !pad_out_o[0])
    else $error("pin 0 driven while regulator owns it");
  a_pin0_segment_wins: assert property ( // RULE15
    !regulator_capacitor_pin0_en_i && display_segment_12_en_i
    |=> pad_oe_o[0] && (pad_out_o[0] == $past(display_segment_12_i)))
    else $error("pin 0 not given to segment 12");
  a_pin0_nq_wins: assert property ( // RULE15
    !regulator_capacitor_pin0_en_i && !display_segment_12_en_i
    && latch_inverted_output_en_i[0]
    |=> pad_oe_o[0] && (pad_out_o[0] == $past(latch_inverted_output_i)))
    else $error("pin 0 not given to inverted latch output");
  a_pin3_common_small: assert property ( // RULE17
    display_common_3_en_i && small_package_i
    |=> pad_oe_o[3] && (pad_out_o[3] == $past(display_common_3_i)))
    else $error("pin 3 not given to common 3");
  // Common 3 exists only on the small package; elsewhere the request is ignored
  a_pin3_common_large: assert property ( // RULE17
    display_common_3_en_i && !small_package_i && !display_segment_15_en_i
    |=> (pad_oe_o[3] == !$past(r.dir[3])) && (pad_out_o[3] == $past(r.latch[3])))
    else $error("pin 3 taken by common 3 on large package");
  a_pin4_capture_large: assert property ( // RULE18
    capture_compare_5_en_i && !small_package_i && !display_segment_4_en_i
    && !latch_true_output_en_i && !comparator1_output_en_i
    |=> (pad_oe_o[4] == !$past(r.dir[4])) && (pad_out_o[4] == $past(r.latch[4])))
    else $error("pin 4 taken by capture 5 on large package");
  a_pin5_cmp_last: assert property ( // RULE16
    comparator2_output_en_i[1] && !regulator_capacitor_pin5_en_i
    && !display_segment_5_en_i && !latch_inverted_output_en_i[1]
    |=> pad_oe_o[5] && (pad_out_o[5] == $past(comparator2_output_i)))
    else $error("pin 5 not given to comparator 2");
  a_pin6_crystal_off: assert property ( // RULE19
    crystal_output_en_i && !regulator_capacitor_pin6_en_i |=> !pad_oe_o[6])
    else $error("pin 6 driven while crystal owns it");
  a_pin6_clock_out: assert property ( // RULE19
    clock_output_en_i && !regulator_capacitor_pin6_en_i && !crystal_output_en_i
    |=> pad_oe_o[6] && (pad_out_o[6] == $past(clock_output_i)))
    else $error("pin 6 not given to clock output");
  a_pin7_clock_in: assert property ( // RULE20
    crystal_or_clock_input_en_i |=> !pad_oe_o[7] && !pad_out_o[7])
    else $error("pin 7 driven while clock input owns it");
  a_latch_only_pins: assert property ( // RULE2
    1'b1 |=> (pad_oe_o[2:1] == ~$past(r.dir[2:1]))
    && (pad_out_o[2:1] == $past(r.latch[2:1])))
    else $error("pins 1 and 2 not following latch");
  a_analog_still_drives: assert property ( // RULE9
    r.analog[0] && !r.dir[0] && (pins.src_en[0] == '0)
    |=> pad_oe_o[0] && (pad_out_o[0] == $past(r.latch[0])))
    else $error("analog pin lost its digital drive");
  a_pwm_d_side: assert property ( // RULE22
    LARGE_VARIANT && r.alt[port_a_pkg::ALT_PWM_B_BIT] && pwm_b_output_en_i
    |=> d_side_pin2_pwm_b_en_o && (d_side_pin2_pwm_b_o == $past(pwm_b_output_i)))
    else $error("PWM B not on d side pin 2");
  a_pwm_c_side: assert property ( // RULE22
    !r.alt[port_a_pkg::ALT_PWM_B_BIT] && pwm_b_output_en_i
    |=> c_side_pin0_pwm_b_en_o && (c_side_pin0_pwm_b_o == $past(pwm_b_output_i)))
    else $error("PWM B not on c side pin 0");
endmodule // port_a_pin_control
`default_nettype wire

// ### tb/pad_model.sv
// Far-side model of the port A pads: block drive wins, else the external level
`timescale 1ns/100ps
`default_nettype none
module pad_model (
  input  wire logic [7:0] pad_out_i,
  input  wire logic [7:0] pad_oe_i,
  input  wire logic [7:0] far_i,
  output logic      [7:0] pad_o
);
  // The external driver yields on every pad that the block enables
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_o[i] = pad_oe_i[i] ? pad_out_i[i] : far_i[i];
    end
  end
endmodule // pad_model
`default_nettype wire

// ### tb/tb_port_a_pin_control.sv
// Self-checking bench for the port A pin control block
`timescale 1ns/100ps
`default_nettype none
module tb_port_a_pin_control;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, s, tg, ce, cv, de, dv;
  logic [7:0]  adr_i, pad_in, pad_out, pad_oe, far, d, q;
  logic [7:0]  dir, lat, ana, alt, ex_oe, ex_out, pins;
  logic [3:0]  sel_i;
  logic [5:0]  ana_en;
  logic [31:0] dat_i, dat_o, e, v;
  int          fail_count, checked, cycles, seed;

  port_a_pin_control port_a_pin_control_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
    .analog_input_enable_o(ana_en), .small_package_i(v[16]),
    .regulator_capacitor_pin0_en_i(e[0]), .regulator_capacitor_pin5_en_i(e[1]),
    .regulator_capacitor_pin6_en_i(e[2]), .crystal_output_en_i(e[3]),
    .crystal_or_clock_input_en_i(e[4]), .clock_output_en_i(e[5]), .clock_output_i(v[0]),
    .display_segment_12_en_i(e[6]), .display_segment_12_i(v[1]),
    .display_common_3_en_i(e[7]), .display_common_3_i(v[2]),
    .display_segment_15_en_i(e[8]), .display_segment_15_i(v[3]),
    .display_segment_4_en_i(e[9]), .display_segment_4_i(v[4]),
    .display_segment_5_en_i(e[10]), .display_segment_5_i(v[5]),
    .display_segment_1_en_i(e[11]), .display_segment_1_i(v[6]),
    .display_segment_2_en_i(e[12]), .display_segment_2_i(v[7]),
    .latch_inverted_output_en_i(e[14:13]), .latch_inverted_output_i(v[8]),
    .latch_true_output_en_i(e[15]), .latch_true_output_i(v[9]),
    .comparator2_output_en_i(e[17:16]), .comparator2_output_i(v[10]),
    .comparator1_output_en_i(e[18]), .comparator1_output_i(v[11]),
    .capture_compare_5_en_i(e[19]), .capture_compare_5_i(v[12]),
    .b_side_pin5_i(v[14]), .c_side_pin4_i(v[15]), .timer_gate_input_o(tg),
    .pwm_b_output_en_i(e[20]), .pwm_b_output_i(v[13]),
    .c_side_pin0_pwm_b_en_o(ce), .c_side_pin0_pwm_b_o(cv),
    .d_side_pin2_pwm_b_en_o(de), .d_side_pin2_pwm_b_o(dv)
  );

  pad_model pad_model_i (.pad_out_i(pad_out), .pad_oe_i(pad_oe), .far_i(far), .pad_o(pad_in));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic test_done();
    $display("checks %0d failures %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Cut a hang short well beyond the expected run of about 1800 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 8000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Classic single cycle; the master waits for ack with no assumed latency
  task automatic wb(input logic w, input logic [7:0] a, input logic sl, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= {3'h0, sl};
    dat_i <= {24'h0, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      $display("CHECK FAILED at %0t: no bus answer", $time);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    wb(1'b0, a, 1'b1, 8'h00);
    chk(q, exp, what);
  endtask

  // Later calls win, so sources are applied lowest priority first
  task automatic ov(input int p, input logic en, input logic o, input logic val);
    if (en) begin
      ex_oe[p] = o;
      ex_out[p] = val;
    end
  endtask

  task automatic model();
    ex_oe = ~dir;
    ex_out = lat;
    ov(0, e[16], 1'b1, v[10]);
    ov(0, e[13], 1'b1, v[8]);
    ov(0, e[6], 1'b1, v[1]);
    ov(0, e[0], 1'b0, 1'b0);
    ov(3, e[8], 1'b1, v[3]);
    ov(3, e[7] & v[16], 1'b1, v[2]);
    ov(4, e[19] & v[16], 1'b1, v[12]);
    ov(4, e[18], 1'b1, v[11]);
    ov(4, e[15], 1'b1, v[9]);
    ov(4, e[9], 1'b1, v[4]);
    ov(5, e[17], 1'b1, v[10]);
    ov(5, e[14], 1'b1, v[8]);
    ov(5, e[10], 1'b1, v[5]);
    ov(5, e[1], 1'b0, 1'b0);
    ov(6, e[11], 1'b1, v[6]);
    ov(6, e[5], 1'b1, v[0]);
    ov(6, e[3], 1'b0, 1'b0);
    ov(6, e[2], 1'b0, 1'b0);
    ov(7, e[12], 1'b1, v[7]);
    ov(7, e[4], 1'b0, 1'b0);
    pins = (ex_oe & ex_out) | (~ex_oe & far);
  endtask

  initial begin
    seed = 32'h6696bef6;
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, far, e, v} = '0;
    rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    dir = port_a_pkg::DIR_RST;
    lat = port_a_pkg::LATCH_RST;
    ana = {2'b00, port_a_pkg::ANALOG_RST};
    alt = {1'b0, port_a_pkg::ALT_RST};
    chk(pad_oe, 8'h00, "reset drive");
    rd_chk(port_a_pkg::OFF_DIRECTION, dir, "reset dir");
    rd_chk(port_a_pkg::OFF_ANALOG, ana, "reset analog");
    rd_chk(port_a_pkg::OFF_LATCH, lat, "reset latch");
    rd_chk(port_a_pkg::OFF_ALT_FUNC, alt, "reset alt");
    wb(1'b1, port_a_pkg::OFF_ANALOG, 1'b1, 8'h00);
    ana = 8'h00;
    for (int k = 0; k < 40; k++) begin
      @(posedge clk_i);
      far <= 8'($random(seed));
      e <= $random(seed) & $random(seed) & $random(seed);
      v <= $random(seed);
      s = 1'($random(seed));
      d = 8'($random(seed));
      wb(1'b1, port_a_pkg::OFF_DIRECTION, s, d);
      dir = s ? d : dir;
      d = 8'($random(seed));
      wb(1'b1, port_a_pkg::OFF_ANALOG, 1'b1, d);
      ana = d & 8'h3F;
      s = 1'($random(seed));
      d = 8'($random(seed));
      wb(1'b1, port_a_pkg::OFF_ALT_FUNC, s, d);
      alt = s ? d & 8'h7F : alt;
      repeat (5) @(posedge clk_i);
      model();
      s = 1'($random(seed));
      d = 8'($random(seed));
      wb(1'b1, k[0] ? port_a_pkg::OFF_LATCH : port_a_pkg::OFF_PIN_VALUE, s, d);
      lat = s ? d : pins & ~ana;
      wb(1'b1, 8'h14, 1'b1, 8'hFF);
      repeat (5) @(posedge clk_i);
      model();
      chk(pad_oe, ex_oe, "pad enable");
      chk(pad_out, ex_out, "pad value");
      chk({2'b00, ana_en}, ana, "analog enable");
      rd_chk(port_a_pkg::OFF_PIN_VALUE, pins & ~ana, "pin read");
      rd_chk(port_a_pkg::OFF_LATCH, lat, "latch read");
      rd_chk(port_a_pkg::OFF_DIRECTION, dir, "dir read");
      rd_chk(port_a_pkg::OFF_ANALOG, ana, "analog read");
      rd_chk(port_a_pkg::OFF_ALT_FUNC, alt, "alt read");
      rd_chk(8'h14, 8'h00, "unmapped read");
      chk({7'h0, tg}, {7'h0, alt[5] ? v[15] : v[14]}, "timer gate");
      chk({4'h0, ce, cv, de, dv}, alt[4] ? {6'h0, e[20], v[13]} : {4'h0, e[20], v[13], 2'b00},
          "pwm b steering");
    end
    // A reset in mid-run must restore analog mode and input direction
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    dir = port_a_pkg::DIR_RST;
    lat = port_a_pkg::LATCH_RST;
    ana = {2'b00, port_a_pkg::ANALOG_RST};
    rd_chk(port_a_pkg::OFF_ANALOG, ana, "analog after reset");
    rd_chk(port_a_pkg::OFF_DIRECTION, dir, "dir after reset");
    rd_chk(port_a_pkg::OFF_LATCH, lat, "latch after reset");
    chk({2'b00, ana_en}, ana, "analog enable after reset");
    test_done();
  end
endmodule // tb_port_a_pin_control
`default_nettype wire
